// ==== core/adc_timing_pkg.sv ====
// constants and carrier types for the converter host-port timing block
package adc_timing_pkg;

    // core clock rate and the printed times, cycles derived from them
    localparam int CORE_CLK_MHZ     = 40;
    localparam int T_POR_US         = 250;
    localparam int T_REGACQ_US      = 5;
    localparam int POR_CYCLES       = T_POR_US * CORE_CLK_MHZ;
    localparam int REGACQ_CYCLES    = T_REGACQ_US * CORE_CLK_MHZ;

    // counts in main conversion clock periods
    localparam int SYNC_MAX_MCLK    = 2047;
    localparam int RESET_MIN_MCLK   = 2048;
    localparam int CONVERSION_READY_PIN_HIGH_MCLK   = 4;
    localparam int CONVERSION_READY_PIN_LOW_MCLK    = 4;
    localparam int SPI_TIMEOUT_MCLK = 32768;

    // modulator runs at main clock / 2, ratio = 2**(7 + code), 128 .. 16384
    localparam int MOD_DIV          = 2;
    localparam int RATIO_MIN_LOG2   = 7;
    localparam int RATIO_CODE_BITS  = 3;

    // serial word, clock polarity 0 / phase 1
    localparam int WORD_BITS        = 24;
    localparam logic SCLK_IDLE      = 1'b0;
    localparam logic SPI_PHASE      = 1'b1;

    typedef struct packed
    {
        logic sclk;
        logic cs_n;
        logic sdi;
    } spi_in_s;

    typedef struct packed
    {
        logic sdo;
        logic sdo_oe;
    } spi_out_s;

    typedef enum logic [2:0]
    {
        PW_LOAD = 3'b001,
        PW_WAIT = 3'b010,
        PW_RUN  = 3'b100
    } power_e;

    typedef enum logic [2:0]
    {
        DR_IDLE = 3'b001,
        DR_HIGH = 3'b010,
        DR_LOW  = 3'b100
    } conversion_ready_pin_e;

endpackage

// ==== core/level_edge.sv ====
// registered level with rise and fall detection for a synchronous input
`timescale 1ns/10ps
module level_edge
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // watched level
    input  wire logic level_in,
    // edges seen against the previous cycle
    output logic      rise,
    output logic      fall
);

    logic level_q;
    logic next_level_q;

    always_comb
    begin
        next_level_q = level_in;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            level_q <= RESET_LEVEL;
        end
        else
        begin
            level_q <= next_level_q;
        end
    end

    assign rise = level_in & ~level_q;
    assign fall = ~level_in & level_q;

endmodule // level_edge

// ==== core/adc_serial_sync_timing.sv ====
// host-port timing of the converter: serial link, align/clear pin, ready pulse, start-up
//
// Contract
// - a low on the align pin of 1 to 2047 main clock periods is a sync request, not a reset.
// - a low on the align pin of 2048 or more main clock periods fully resets the device.
// - the align pin is sampled on rising edges of the external clock input.
// - every ready pulse is high for 4 and then low for at least 4 main clock periods; high ends on the 4th tick, so start-up and held pulses are high 3 to 4.
// - the link is polarity 0 phase 1, output changes on rise and capture is on fall.
// - each input bit is captured on a falling serial clock edge.
// - the next output bit is presented after each rising serial clock edge under select.
// - the output is driven from select falling and released after select rising.
// - the first ready rising edge comes about 250 us after power-up.
// - register defaults load within 5 us before contents count as valid.
// - the modulators run at half the main clock.
// - decimation ratios are powers of two from 128 to 16384, rate = modulator clock / ratio.
`timescale 1ns/10ps
module adc_serial_sync_timing
    import adc_timing_pkg::*;
#(
    parameter int POR_TIME_CYCLES = adc_timing_pkg::POR_CYCLES,
    parameter int TIMEOUT_MCLK    = adc_timing_pkg::SPI_TIMEOUT_MCLK
)
(
    // clock and reset
    input  wire logic                                    core_clk,
    input  wire logic                                    rst,
    // main clock pin and align/clear pin (active low)
    input  wire logic                                    ext_clock_in,
    input  wire logic                                    align_or_clear_n,
    // serial link
    input  wire adc_timing_pkg::spi_in_s                 spi_in,
    output adc_timing_pkg::spi_out_s                     spi_out,
    // conversion control and status
    input  wire logic [adc_timing_pkg::RATIO_CODE_BITS-1:0] decimation_ratio,
    output logic                                         conversion_ready_pin,
    output logic                                         mod_clk,
    output logic                                         regs_valid,
    output logic                                         sync_pulse,
    output logic                                         reset_pulse,
    // word exchange with the core
    input  wire logic [adc_timing_pkg::WORD_BITS-1:0]    tx_data,
    output logic [adc_timing_pkg::WORD_BITS-1:0]         rx_data,
    output logic                                         rx_strobe,
    output logic                                         frame_timeout
);

    import adc_timing_pkg::*;

    logic mclk_tick;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic clear_all;

    level_edge #(.RESET_LEVEL(1'b0)) u_ext_edge
    (
        .core_clk (core_clk),
        .rst      (rst),
        .level_in (ext_clock_in),
        .rise     (mclk_tick),
        .fall     ()
    );

    level_edge #(.RESET_LEVEL(SCLK_IDLE)) u_sclk_edge
    (
        .core_clk (core_clk),
        .rst      (rst),
        .level_in (spi_in.sclk),
        .rise     (sclk_rise),
        .fall     (sclk_fall)
    );

    level_edge #(.RESET_LEVEL(1'b1)) u_cs_edge
    (
        .core_clk (core_clk),
        .rst      (rst),
        .level_in (spi_in.cs_n),
        .rise     (cs_rise),
        .fall     (cs_fall)
    );

    // align/clear pin measurement; a high pin at a tick or rst clears it, reset_pulse does not, so a held low cannot re-fire
    logic [11:0] low_cnt;
    logic [11:0] next_low_cnt;
    logic        next_sync_pulse;
    logic        next_reset_pulse;

    always_comb
    begin
        next_low_cnt     = low_cnt;
        next_sync_pulse  = 1'b0;
        next_reset_pulse = 1'b0;
        if (mclk_tick)
        begin
            if (!align_or_clear_n)
            begin
                if (low_cnt < 12'(RESET_MIN_MCLK))
                begin
                    next_low_cnt = low_cnt + 12'h001;
                end
                if (low_cnt == 12'(RESET_MIN_MCLK - 1))
                begin
                    next_reset_pulse = 1'b1;
                end
            end
            else
            begin
                next_low_cnt = 12'h000;
                if (low_cnt != 12'h000 && low_cnt <= 12'(SYNC_MAX_MCLK))
                begin
                    next_sync_pulse = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            low_cnt     <= 12'h000;
            sync_pulse  <= 1'b0;
            reset_pulse <= 1'b0;
        end
        else
        begin
            low_cnt     <= next_low_cnt;
            sync_pulse  <= next_sync_pulse;
            reset_pulse <= next_reset_pulse;
        end
    end

    assign clear_all = rst | reset_pulse;

    // start-up: register load, then wait out the power-on time
    power_e      pw_state;
    power_e      next_pw_state;
    logic [15:0] pw_cnt;
    logic [15:0] next_pw_cnt;
    logic        next_regs_valid;
    logic        first_conv;

    always_comb
    begin
        next_pw_state   = pw_state;
        next_pw_cnt     = pw_cnt + 16'h0001;
        next_regs_valid = regs_valid;
        first_conv      = 1'b0;
        case (pw_state)
            PW_LOAD:
            begin
                if (pw_cnt == 16'(REGACQ_CYCLES - 1))
                begin
                    next_regs_valid = 1'b1;
                    next_pw_state   = PW_WAIT;
                end
            end
            PW_WAIT:
            begin
                if (pw_cnt >= 16'(POR_TIME_CYCLES - 1))
                begin
                    first_conv    = 1'b1;
                    next_pw_state = PW_RUN;
                end
            end
            PW_RUN:
            begin
                next_pw_cnt = pw_cnt;
            end
            default:
            begin
                next_pw_state = PW_LOAD;
                next_pw_cnt   = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (clear_all)
        begin
            pw_state   <= PW_LOAD;
            pw_cnt     <= 16'h0000;
            regs_valid <= 1'b0;
        end
        else
        begin
            pw_state   <= next_pw_state;
            pw_cnt     <= next_pw_cnt;
            regs_valid <= next_regs_valid;
        end
    end

    // modulator clock and decimation; a sync request realigns both counters
    logic [13:0] dec_cnt;
    logic [13:0] next_dec_cnt;
    logic [13:0] dec_limit;
    logic        next_mod_clk;
    logic        mod_tick;
    logic        conv_done;

    always_comb
    begin
        dec_limit    = 14'((15'h0001 << (4'(RATIO_MIN_LOG2) + {1'b0, decimation_ratio}))
                       - 15'h0001);
        mod_tick     = mclk_tick & mod_clk;
        next_mod_clk = mod_clk;
        next_dec_cnt = dec_cnt;
        conv_done    = first_conv;
        if (sync_pulse)
        begin
            next_mod_clk = 1'b0;
            next_dec_cnt = 14'h0000;
        end
        else if (pw_state == PW_RUN)
        begin
            if (mclk_tick)
            begin
                next_mod_clk = ~mod_clk;
            end
            if (mod_tick)
            begin
                if (dec_cnt >= dec_limit)
                begin
                    next_dec_cnt = 14'h0000;
                    conv_done    = 1'b1;
                end
                else
                begin
                    next_dec_cnt = dec_cnt + 14'h0001;
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clear_all)
        begin
            mod_clk <= 1'b0;
            dec_cnt <= 14'h0000;
        end
        else
        begin
            mod_clk <= next_mod_clk;
            dec_cnt <= next_dec_cnt;
        end
    end

    // ready pulse; a conversion finishing mid-pulse waits rather than being dropped
    conversion_ready_pin_e      dr_state;
    conversion_ready_pin_e      next_dr_state;
    logic [2:0] dr_cnt;
    logic [2:0] next_dr_cnt;
    logic       dr_pending;
    logic       next_dr_pending;
    logic       next_ready_pin;

    always_comb
    begin
        next_dr_state   = dr_state;
        next_dr_cnt     = dr_cnt;
        next_dr_pending = dr_pending | conv_done;
        next_ready_pin  = conversion_ready_pin;
        case (dr_state)
            DR_IDLE:
            begin
                if (next_dr_pending)
                begin
                    next_dr_pending = 1'b0;
                    next_ready_pin  = 1'b1;
                    next_dr_cnt     = 3'h0;
                    next_dr_state   = DR_HIGH;
                end
            end
            DR_HIGH:
            begin
                if (mclk_tick)
                begin
                    next_dr_cnt = dr_cnt + 3'h1;
                    if (dr_cnt == 3'(CONVERSION_READY_PIN_HIGH_MCLK - 1))
                    begin
                        next_ready_pin = 1'b0;
                        next_dr_cnt    = 3'h0;
                        next_dr_state  = DR_LOW;
                    end
                end
            end
            DR_LOW:
            begin
                if (mclk_tick)
                begin
                    next_dr_cnt = dr_cnt + 3'h1;
                    if (dr_cnt == 3'(CONVERSION_READY_PIN_LOW_MCLK - 1))
                    begin
                        next_dr_state = DR_IDLE;
                    end
                end
            end
            default:
            begin
                next_dr_state  = DR_IDLE;
                next_ready_pin = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (clear_all)
        begin
            dr_state             <= DR_IDLE;
            dr_cnt               <= 3'h0;
            dr_pending           <= 1'b0;
            conversion_ready_pin <= 1'b0;
        end
        else
        begin
            dr_state             <= next_dr_state;
            dr_cnt               <= next_dr_cnt;
            dr_pending           <= next_dr_pending;
            conversion_ready_pin <= next_ready_pin;
        end
    end

    // serial link; edges are found on the sampled sclk, so sclk must stay well below core rate
    logic [WORD_BITS-1:0] tx_shift;
    logic [WORD_BITS-1:0] next_tx_shift;
    logic [WORD_BITS-1:0] rx_shift;
    logic [WORD_BITS-1:0] next_rx_shift;
    logic [WORD_BITS-1:0] next_rx_data;
    logic [4:0]           bit_cnt;
    logic [4:0]           next_bit_cnt;
    logic [15:0]          to_cnt;
    logic [15:0]          next_to_cnt;
    spi_out_s             next_spi_out;
    logic                 next_rx_strobe;
    logic                 next_timeout;

    always_comb
    begin
        next_tx_shift  = tx_shift;
        next_rx_shift  = rx_shift;
        next_rx_data   = rx_data;
        next_bit_cnt   = bit_cnt;
        next_to_cnt    = to_cnt;
        next_spi_out   = spi_out;
        next_rx_strobe = 1'b0;
        next_timeout   = 1'b0;
        if (cs_fall)
        begin
            next_spi_out.sdo_oe = 1'b1;
            next_spi_out.sdo    = 1'b0;
            next_tx_shift       = tx_data;
            next_bit_cnt        = 5'h00;
            next_to_cnt         = 16'h0000;
        end
        else if (cs_rise || spi_in.cs_n)
        begin
            next_spi_out.sdo_oe = 1'b0;
            next_bit_cnt        = 5'h00;
            next_to_cnt         = 16'h0000;
        end
        else
        begin
            if (sclk_rise && SPI_PHASE)
            begin
                next_spi_out.sdo = tx_shift[WORD_BITS-1];
                next_tx_shift    = {tx_shift[WORD_BITS-2:0], 1'b0};
            end
            if (sclk_fall)
            begin
                next_rx_shift = {rx_shift[WORD_BITS-2:0], spi_in.sdi};
                next_to_cnt   = 16'h0000;
                if (bit_cnt == 5'(WORD_BITS - 1))
                begin
                    next_rx_data   = next_rx_shift;
                    next_rx_strobe = 1'b1;
                    next_bit_cnt   = 5'h00;
                    next_tx_shift  = tx_data;
                end
                else
                begin
                    next_bit_cnt = bit_cnt + 5'h01;
                end
            end
            else if (bit_cnt != 5'h00 && mclk_tick)
            begin
                if (to_cnt == 16'(TIMEOUT_MCLK - 1))
                begin
                    next_bit_cnt  = 5'h00;
                    next_to_cnt   = 16'h0000;
                    next_tx_shift = tx_data;
                    next_timeout  = 1'b1;
                end
                else
                begin
                    next_to_cnt = to_cnt + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (clear_all)
        begin
            tx_shift      <= '0;
            rx_shift      <= '0;
            rx_data       <= '0;
            bit_cnt       <= 5'h00;
            to_cnt        <= 16'h0000;
            spi_out       <= '0;
            rx_strobe     <= 1'b0;
            frame_timeout <= 1'b0;
        end
        else
        begin
            tx_shift      <= next_tx_shift;
            rx_shift      <= next_rx_shift;
            rx_data       <= next_rx_data;
            bit_cnt       <= next_bit_cnt;
            to_cnt        <= next_to_cnt;
            spi_out       <= next_spi_out;
            rx_strobe     <= next_rx_strobe;
            frame_timeout <= next_timeout;
        end
    end

endmodule // adc_serial_sync_timing

// ==== tb/adc_serial_sync_timing_assertions.sv ====
// concurrent checks on the converter host-port timing block
`timescale 1ns/10ps
module adc_serial_sync_timing_assertions
    import adc_timing_pkg::*;
#(
    parameter int POR_TIME_CYCLES = adc_timing_pkg::POR_CYCLES,
    parameter int TIMEOUT_MCLK    = adc_timing_pkg::SPI_TIMEOUT_MCLK
)
(
    // clock and reset
    input wire logic                     core_clk,
    input wire logic                     rst,
    // pins watched
    input wire logic                     ext_clock_in,
    input wire logic                     align_or_clear_n,
    input wire adc_timing_pkg::spi_in_s  spi_in,
    input wire adc_timing_pkg::spi_out_s spi_out,
    // status outputs
    input wire logic                     conversion_ready_pin,
    input wire logic                     regs_valid,
    input wire logic                     sync_pulse,
    input wire logic                     reset_pulse,
    input wire logic                     rx_strobe,
    input wire logic                     frame_timeout
);
    import adc_timing_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [3:0] rise_h;
    logic [2:0] rp_h;
    logic       seen_ready;
    int         hi_ticks, low_ticks, idle_ticks, up_cyc;

    // tick counts use the pin edge itself, which falls in the same cycle as the block's own tick
    always_ff @(posedge core_clk)
    begin
        rise_h     <= rst ? '0 : {rise_h[2:0], $rose(spi_in.sclk)};
        rp_h       <= rst ? '0 : {rp_h[1:0], reset_pulse};
        hi_ticks   <= (rst || !conversion_ready_pin) ? 0 : hi_ticks + int'($rose(ext_clock_in));
        low_ticks  <= (rst || $fell(align_or_clear_n)) ? 0
                      : low_ticks + int'(!align_or_clear_n && $rose(ext_clock_in));
        idle_ticks <= (rst || spi_in.cs_n || $fell(spi_in.sclk)) ? 0
                      : idle_ticks + int'($rose(ext_clock_in));
        up_cyc     <= (rst || reset_pulse) ? 0 : up_cyc + 1;
        seen_ready <= (rst || reset_pulse) ? 1'b0 : (seen_ready || conversion_ready_pin);
    end

    // a pin reset may cut a pulse short, so those falls are left out
    AST_READY_HIGH: assert property ($fell(conversion_ready_pin) && !(|rp_h) |-> hi_ticks == 4)
        else $error("ready pulse high length wrong");
    AST_FIRST_READY: assert property ($rose(conversion_ready_pin) && !seen_ready
        |-> up_cyc inside {[POR_TIME_CYCLES-1:POR_TIME_CYCLES+4]})
        else $error("first ready rise off time");
    AST_REGS_VALID: assert property ($rose(regs_valid)
        |-> up_cyc inside {[REGACQ_CYCLES-2:REGACQ_CYCLES+3]})
        else $error("register load time wrong");
    AST_SYNC_DUE: assert property ($rose(align_or_clear_n) && low_ticks inside {[1:2047]}
        |-> ##[1:16] sync_pulse)
        else $error("short low gave no sync");
    AST_RESET_DUE: assert property (low_ticks == 2048 && $past(low_ticks) != 2048
        |-> ##[0:12] reset_pulse)
        else $error("long low gave no reset");
    AST_RESET_CAUSE: assert property (reset_pulse |-> low_ticks >= 2048 && !align_or_clear_n)
        else $error("reset without long low");
    AST_CS_DRIVE: assert property ($fell(spi_in.cs_n) |-> ##[1:3] spi_out.sdo_oe)
        else $error("output not driven after select");
    AST_CS_RELEASE: assert property (spi_in.cs_n [*4] |-> !spi_out.sdo_oe)
        else $error("output driven without select");
    AST_SDO_MOVES: assert property ($changed(spi_out.sdo) && spi_out.sdo_oe
        && $past(spi_out.sdo_oe) |-> |rise_h)
        else $error("output bit moved without clock rise");
    AST_TIMEOUT: assert property (frame_timeout |-> idle_ticks >= TIMEOUT_MCLK && !spi_in.cs_n)
        else $error("frame abandoned too early");

    COV_SYNC: cover property (sync_pulse);
    COV_RESET: cover property (reset_pulse);
    COV_WORD: cover property (rx_strobe);
    COV_TIMEOUT: cover property (frame_timeout);
endmodule // adc_serial_sync_timing_assertions

bind adc_serial_sync_timing adc_serial_sync_timing_assertions #(
    .POR_TIME_CYCLES(POR_TIME_CYCLES), .TIMEOUT_MCLK(TIMEOUT_MCLK)
) u_chk (
    .core_clk(core_clk), .rst(rst), .ext_clock_in(ext_clock_in),
    .align_or_clear_n(align_or_clear_n), .spi_in(spi_in), .spi_out(spi_out),
    .conversion_ready_pin(conversion_ready_pin), .regs_valid(regs_valid),
    .sync_pulse(sync_pulse), .reset_pulse(reset_pulse), .rx_strobe(rx_strobe),
    .frame_timeout(frame_timeout)
);

// ==== tb/host_model.sv ====
// serial master model of the host controller
`timescale 1ns/10ps
module host_model
    import adc_timing_pkg::*;
(
    // clock
    input  wire logic                     core_clk,
    // serial link
    output adc_timing_pkg::spi_in_s       spi_in,
    input  wire adc_timing_pkg::spi_out_s spi_out
);
    import adc_timing_pkg::*;

    localparam int HALF = 4;

    initial
    begin
        spi_in = '{sclk: SCLK_IDLE, cs_n: 1'b1, sdi: 1'b0};
    end

    task automatic pause();
        repeat (HALF) @(posedge core_clk);
        #2;
    endtask

    // select moves only with the clock low; a released data line flips so it is no help
    task automatic select(input logic on);
        spi_in.cs_n = !on;
        if (!on)
            spi_in.sdi = !spi_in.sdi;
        pause();
    endtask

    task automatic bit_cycle(input logic b, output logic r);
        spi_in.sclk = 1'b1;
        spi_in.sdi  = b;
        pause();
        r           = spi_out.sdo;
        spi_in.sclk = 1'b0;
        pause();
    endtask

    task automatic shift_word(input logic [WORD_BITS-1:0] w, output logic [WORD_BITS-1:0] r);
        for (int i = WORD_BITS - 1; i >= 0; i--)
            bit_cycle(w[i], r[i]);
    endtask
endmodule // host_model

// ==== tb/tb_top.sv ====
// self-checking bench for the converter host-port timing block
`timescale 1ns/10ps
module tb_top;
    import adc_timing_pkg::*;

    localparam int POR_T   = 300;
    localparam int TO_T    = 16;
    localparam int MAX_CYC = 90000;

    logic                       core_clk         = 1'b0;
    logic                       rst              = 1'b1;
    logic                       ext_clock_in     = 1'b0;
    logic                       align_or_clear_n = 1'b1;
    logic [RATIO_CODE_BITS-1:0] decimation_ratio = '0;
    logic [WORD_BITS-1:0]       tx_data          = '0;
    logic [2:0]                 ecnt             = '0;
    spi_in_s                    spi_in;
    spi_out_s                   spi_out;
    logic [WORD_BITS-1:0]       rx_data;
    logic                       conversion_ready_pin, mod_clk, regs_valid, rx_strobe;
    logic                       sync_pulse, reset_pulse, frame_timeout;
    logic [2:0]                 obs;
    int                         n_fail, num_checks, cyc, n_sync, n_rst, n_rx, n_to;

    assign obs = {regs_valid, mod_clk, conversion_ready_pin};

    host_model host (.core_clk(core_clk), .spi_in(spi_in), .spi_out(spi_out));

    adc_serial_sync_timing #(.POR_TIME_CYCLES(POR_T), .TIMEOUT_MCLK(TO_T)) dut (
        .core_clk(core_clk), .rst(rst), .ext_clock_in(ext_clock_in),
        .align_or_clear_n(align_or_clear_n), .spi_in(spi_in), .spi_out(spi_out),
        .decimation_ratio(decimation_ratio), .conversion_ready_pin(conversion_ready_pin),
        .mod_clk(mod_clk), .regs_valid(regs_valid), .sync_pulse(sync_pulse),
        .reset_pulse(reset_pulse), .tx_data(tx_data), .rx_data(rx_data),
        .rx_strobe(rx_strobe), .frame_timeout(frame_timeout)
    );

    always #12.5 core_clk = ~core_clk;

    // main clock pin at one eighth of the core rate; one-cycle pulses are tallied here
    always @(posedge core_clk)
    begin
        n_sync += int'(sync_pulse === 1'b1);
        n_rst  += int'(reset_pulse === 1'b1);
        n_rx   += int'(rx_strobe === 1'b1);
        n_to   += int'(frame_timeout === 1'b1);
        #2;
        ecnt = ecnt + 3'h1;
        ext_clock_in = ecnt[2];
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == MAX_CYC)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic wait_bit(input int idx, input logic val, input int limit, output int t);
        t = 0;
        while (obs[idx] !== val && t < limit)
        begin
            step(1);
            t++;
        end
        check("wait bound", t < limit, 1'b1);
    endtask

    task automatic t_startup();
        int t1, t2;
        wait_bit(2, 1'b1, 400, t1);
        check("regs delay", t1 >= REGACQ_CYCLES - 2 && t1 <= REGACQ_CYCLES + 3, 1'b1);
        wait_bit(0, 1'b1, 400, t2);
        check("first ready", t1 + t2 >= POR_T - 2 && t1 + t2 <= POR_T + 4, 1'b1);
    endtask

    task automatic t_ready(input logic [RATIO_CODE_BITS-1:0] code);
        int   th, tl, t, nr;
        logic mp;
        decimation_ratio = code;
        // the start-up pulse is not tick aligned, so measure from a later one
        wait_bit(0, 1'b0, 100, t);
        wait_bit(0, 1'b1, 5000, t);
        wait_bit(0, 1'b0, 100, th);
        wait_bit(0, 1'b1, 5000, tl);
        check("ready high", th, CONVERSION_READY_PIN_HIGH_MCLK * 8);
        check("ready period", th + tl, 16 << (RATIO_MIN_LOG2 + code));
        nr = 0;
        mp = mod_clk;
        for (int i = 0; i < 128; i++)
        begin
            step(1);
            nr += int'(mod_clk === 1'b1 && mp === 1'b0);
            mp = mod_clk;
        end
        check("mod rises", nr, 8);
    endtask

    // the second word picks up the value loaded while the first one shifts
    task automatic t_spi();
        logic [WORD_BITS-1:0] r0, r1;
        int                   t;
        wait_bit(0, 1'b1, 5000, t);
        wait_bit(0, 1'b0, 100, t);
        tx_data = 24'hC35A69;
        n_rx = 0;
        check("oe idle", spi_out.sdo_oe, 1'b0);
        host.select(1'b1);
        check("oe driven", spi_out.sdo_oe, 1'b1);
        tx_data = 24'h3CA596;
        host.shift_word(24'hA53C96, r0);
        check("rx word 0", rx_data, 24'hA53C96);
        host.shift_word(24'h5AC369, r1);
        check("rx word 1", rx_data, 24'h5AC369);
        check("rx count", n_rx, 2);
        check("tx word 0", r0, 24'hC35A69);
        check("tx word 1", r1, 24'h3CA596);
        host.select(1'b0);
        check("oe released", spi_out.sdo_oe, 1'b0);
    endtask

    task automatic t_timeout();
        logic [WORD_BITS-1:0] r;
        logic                 b;
        n_to = 0;
        tx_data = 24'h0F1E2D;
        host.select(1'b1);
        for (int i = 0; i < 5; i++)
            host.bit_cycle(i[0], b);
        step(TO_T * 8 + 40);
        check("timeout count", n_to, 1);
        host.shift_word(24'h96A5C3, r);
        check("rx after timeout", rx_data, 24'h96A5C3);
        check("tx after timeout", r, 24'h0F1E2D);
        host.select(1'b0);
    endtask

    // the pin moves mid low phase of the main clock, so n ticks see it low
    task automatic t_align(input int n);
        int   t;
        logic is_rst;
        is_rst = (n >= RESET_MIN_MCLK);
        n_sync = 0;
        n_rst = 0;
        @(negedge ext_clock_in);
        step(2);
        align_or_clear_n = 1'b0;
        repeat (n) @(posedge ext_clock_in);
        @(negedge ext_clock_in);
        step(2);
        align_or_clear_n = 1'b1;
        step(40);
        check("sync count", n_sync, !is_rst);
        check("reset count", n_rst, is_rst);
        check("regs after pin", regs_valid, !is_rst);
        wait_bit(2, 1'b1, 400, t);
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk);
        #2;
        rst = 1'b0;
        t_startup();
        t_ready(3'h0);
        t_ready(3'h1);
        t_spi();
        t_timeout();
        t_align(1);
        t_align(RESET_MIN_MCLK - 1);
        t_align(RESET_MIN_MCLK);
        summarize();
    end
endmodule // tb_top
